// ---- inc/ebs_pkg.sv ----
// package: constants for the expansion bus strobe and fetch select block
package ebs_pkg;
   // register map (8-bit special function register space)
   localparam logic [7:0] EBS_AUX_BUS_CTRL_ADDR = 8'h8E;
   localparam logic [7:0] EBS_STATUS_ADDR       = 8'h8F;
   localparam logic [7:0] EBS_AUX_RESET_VAL     = 8'h00;
   // auxiliary register field positions
   localparam int EBS_STROBE_SUPPRESS_BIT  = 0;
   localparam int EBS_DATA_SPACE_SEL_BIT   = 1;
   localparam int EBS_XRAM_SIZE_LO_BIT     = 2;
   localparam int EBS_XRAM_SIZE_HI_BIT     = 3;
   localparam int EBS_MOVE_STRETCH_BIT     = 5;
   localparam int EBS_WEAK_PULLUP_DIS_BIT  = 7;
   // writable bits: reserved bits 6 and 4 stay zero
   localparam logic [7:0] EBS_AUX_WRITE_MASK = 8'hAF;
   // program space layout
   localparam logic [15:0] EBS_TOP_16K = 16'h3FFF;
   localparam logic [15:0] EBS_TOP_32K = 16'h7FFF;
   // strobe cadence: one pulse per machine cycle of this many clocks
   localparam int EBS_MACHINE_CYCLE = 6;
   localparam int EBS_STROBE_HIGH   = 2;
   // bus access kinds
   typedef enum logic [1:0] {
      EBS_ACC_NONE,
      EBS_ACC_FETCH,
      EBS_ACC_DATA_MOVE,
      EBS_ACC_TABLE_READ
   } ebs_access_t;
endpackage

// ---- hw/ebs_strobe_gen.sv ----
// strobe generator: address latch strobe pin with weak pull-up handling
`timescale 1ns/1ps
`default_nettype none
module ebs_strobe_gen
   import ebs_pkg::*;
(
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_srst,
   input  wire logic i_ce,
   // control
   input  wire logic i_suppress,
   input  wire logic i_ext_active,
   // pin
   output logic      o_strobe,
   output logic      o_strobe_oe,
   output logic      o_pullup_en
);
   logic [3:0] phase_reg;
   logic       emit;

   // emitting whenever not suppressed or an external access runs
   assign emit = !i_suppress || i_ext_active;

   // machine cycle phase counter
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         phase_reg <= 4'h0;
      end else if (i_ce) begin
         if (phase_reg == 4'(EBS_MACHINE_CYCLE - 1)) begin
            phase_reg <= 4'h0;
         end else begin
            phase_reg <= phase_reg + 4'h1;
         end
      end
   end

   // pin drive: released to the pull-up while suppressed and idle
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_strobe    <= 1'b0;
         o_strobe_oe <= 1'b1;
         o_pullup_en <= 1'b0;
      end else if (i_ce) begin
         // an access that leaves the released state gets a pulse at once, so a short suppressed access is never strobe-less
         o_strobe    <= emit && (phase_reg < 4'(EBS_STROBE_HIGH) || (i_suppress && !o_strobe_oe));
         o_strobe_oe <= emit;
         o_pullup_en <= !emit;
      end
   end

   chk_released_idle: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && i_suppress && !i_ext_active) |=> (!o_strobe_oe && o_pullup_en))
      else $error("strobe pin driven while suppressed and idle");
   chk_strobe_runs: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && !i_suppress && phase_reg == 4'h0) |=> (o_strobe && o_strobe_oe))
      else $error("strobe missing while not suppressed");
   chk_access_pulse: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && i_suppress && i_ext_active && !o_strobe_oe) |=> o_strobe)
      else $error("no strobe pulse at start of a suppressed access");
endmodule
`default_nettype wire

// ---- hw/ebs_top.sv ----
// top: expansion bus strobe control and internal/external fetch select
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ebs_top
   import ebs_pkg::*;
#(
   parameter bit FLASH_32K = 1'b1
)
(
   // clock, reset, enable
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   input  wire logic        i_ce,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // core access requests (same clock)
   input  wire logic        i_fetch_req,
   input  wire logic [15:0] i_pc,
   input  wire logic        i_data_move,
   input  wire logic        i_table_read,
   // external access select pin
   input  wire logic        i_external_access_select,
   // fetch routing
   output logic             o_fetch_internal,
   output logic             o_fetch_external,
   output logic             o_ext_cycle,
   // strobe pin
   output logic             o_strobe,
   output logic             o_strobe_oe,
   output logic             o_pullup_en,
   // control levels to the bus datapath
   output logic             o_data_space_select,
   output logic             o_move_stretch,
   output logic [1:0]       o_xram_size,
   output logic             o_weak_pullup_disable
);
   logic [7:0]  aux_reg;
   logic        sel_meta_reg;
   logic        sel_sync_reg;
   logic        ext_fetch;
   logic        ext_active;
   logic [15:0] flash_top;
   ebs_access_t last_access_reg;

   // decide whether a program address lives in internal flash
   function automatic logic in_flash(input logic [15:0] pc, input logic [15:0] top);
      in_flash = (pc <= top);
   endfunction

   assign flash_top = FLASH_32K ? EBS_TOP_32K : EBS_TOP_16K;

   // access pin is asynchronous: two flops before use
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         sel_meta_reg <= 1'b1;
         sel_sync_reg <= 1'b1;
      end else if (i_ce) begin
         sel_meta_reg <= i_external_access_select;
         sel_sync_reg <= sel_meta_reg;
      end
   end

   // pin low forces external, otherwise addresses above flash go out
   assign ext_fetch = i_fetch_req && (!sel_sync_reg || !in_flash(i_pc, flash_top));
   assign ext_active = ext_fetch || i_data_move || i_table_read;

   // auxiliary register: reserved bits held at zero
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         aux_reg <= EBS_AUX_RESET_VAL;
      end else if (i_ce && i_wr && i_addr == EBS_AUX_BUS_CTRL_ADDR) begin
         aux_reg <= i_wdata & EBS_AUX_WRITE_MASK;
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         if (i_rd && i_addr == EBS_AUX_BUS_CTRL_ADDR) begin
            o_rdata <= aux_reg;
         end else if (i_rd && i_addr == EBS_STATUS_ADDR) begin
            o_rdata <= {4'h0, last_access_reg, sel_sync_reg, FLASH_32K};
         end else begin
            o_rdata <= 8'h00;
         end
      end
   end

   // remembers the latest external access kind for status reads
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         last_access_reg <= EBS_ACC_NONE;
      end else if (i_ce) begin
         case (1'b1)
            ext_fetch:    last_access_reg <= EBS_ACC_FETCH;
            i_data_move:  last_access_reg <= EBS_ACC_DATA_MOVE;
            i_table_read: last_access_reg <= EBS_ACC_TABLE_READ;
            default:      last_access_reg <= last_access_reg;
         endcase
      end
   end

   // registered fetch routing, one cycle after the request
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_fetch_internal <= 1'b0;
         o_fetch_external <= 1'b0;
         o_ext_cycle      <= 1'b0;
      end else if (i_ce) begin
         o_fetch_internal <= i_fetch_req && !ext_fetch;
         o_fetch_external <= ext_fetch;
         o_ext_cycle      <= ext_active;
      end
   end

   // control levels registered from the register bits, one cycle behind
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_data_space_select   <= 1'b0;
         o_move_stretch        <= 1'b0;
         o_xram_size           <= 2'b00;
         o_weak_pullup_disable <= 1'b0;
      end else if (i_ce) begin
         o_data_space_select   <= aux_reg[EBS_DATA_SPACE_SEL_BIT];
         o_move_stretch        <= aux_reg[EBS_MOVE_STRETCH_BIT];
         o_xram_size           <= {aux_reg[EBS_XRAM_SIZE_HI_BIT], aux_reg[EBS_XRAM_SIZE_LO_BIT]};
         o_weak_pullup_disable <= aux_reg[EBS_WEAK_PULLUP_DIS_BIT];
      end
   end

   // strobe pin generator
   ebs_strobe_gen u_strobe (
      .i_clock      (i_clock),
      .i_srst       (i_srst),
      .i_ce         (i_ce),
      .i_suppress   (aux_reg[EBS_STROBE_SUPPRESS_BIT]),
      .i_ext_active (ext_active),
      .o_strobe     (o_strobe),
      .o_strobe_oe  (o_strobe_oe),
      .o_pullup_en  (o_pullup_en)
   );

   sequence s_ext_request;
      i_ce && ext_active;
   endsequence

   chk_ext_drives_pin: assert property (@(posedge i_clock) disable iff (i_srst)
      s_ext_request |=> o_strobe_oe && o_ext_cycle)
      else $error("external access without strobe drive");
   chk_pin_low_ext: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && i_fetch_req && !sel_sync_reg) |=> o_fetch_external && !o_fetch_internal)
      else $error("fetch not external with access pin low");
   chk_high_internal: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && i_fetch_req && sel_sync_reg && i_pc <= flash_top) |=> o_fetch_internal)
      else $error("in-range fetch not internal");
   chk_above_top_ext: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && i_fetch_req && sel_sync_reg && i_pc > flash_top) |=> o_fetch_external)
      else $error("above-range fetch not external");
   // the last flash address is the edge case most easily lost to an off-by-one compare
   chk_flash_bound: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && i_fetch_req && sel_sync_reg && i_pc == flash_top) |=> o_fetch_internal && !o_fetch_external)
      else $error("top flash address not fetched internally");
   chk_reset_clear: assert property (@(posedge i_clock)
      i_srst |=> aux_reg == EBS_AUX_RESET_VAL && o_strobe_oe)
      else $error("suppress bit not cleared by reset");
   chk_suppress_write: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && i_wr && i_addr == EBS_AUX_BUS_CTRL_ADDR)
      |=> aux_reg[EBS_STROBE_SUPPRESS_BIT] == $past(i_wdata[EBS_STROBE_SUPPRESS_BIT]))
      else $error("suppress bit write lost");
   chk_idle_release: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && aux_reg[EBS_STROBE_SUPPRESS_BIT] && !ext_active) |=> !o_strobe_oe ##0 o_pullup_en)
      else $error("strobe pin not released");
   chk_free_running: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && !aux_reg[EBS_STROBE_SUPPRESS_BIT]) |=> o_strobe_oe)
      else $error("strobe stopped while not suppressed");
   // read data stand one cycle only, so a stale value cannot be taken twice
   chk_read_zero: assert property (@(posedge i_clock) disable iff (i_srst)
      (i_ce && !i_rd) |=> o_rdata == '0)
      else $error("read data not cleared after the read cycle");
   // enable low freezes the control register, writes included
   chk_ce_freeze: assert property (@(posedge i_clock) disable iff (i_srst)
      !i_ce |=> $stable(aux_reg))
      else $error("control register moved while clock enable low");
endmodule
`default_nettype wire

// ---- dv/ebs_ext_mem.sv ----
// partner model: external memory side, resolves the latch strobe pin level
`timescale 1ns/1ps
`default_nettype none
module ebs_ext_mem (
   // strobe pin as driven by the device
   input  wire logic i_clock,
   input  wire logic i_strobe,
   input  wire logic i_strobe_oe,
   input  wire logic i_pullup_en,
   // resolved pin level seen by the address latch
   output logic      o_pin
);
   logic last_reg = 1'b0;
   // a released pin without pull-up must not keep its old level, so show a toggling one
   always_comb o_pin = i_strobe_oe ? i_strobe : (i_pullup_en ? 1'b1 : ~last_reg);
   // remember the last pin level for the floating case
   always_ff @(posedge i_clock) begin
      last_reg <= o_pin;
   end
endmodule
`default_nettype wire

// ---- dv/test_ebs_top.sv ----
// testbench: register port, strobe cadence and fetch routing against a model
`timescale 1ns/1ps
`default_nettype none
module test_ebs_top;
   import ebs_pkg::*;
   logic        i_clock = 0, i_srst = 1, i_ce = 1, i_wr = 0, i_rd = 0, i_fetch_req = 0;
   logic        i_data_move = 0, i_table_read = 0, i_external_access_select = 1;
   logic [7:0]  i_addr = '0, i_wdata = '0, o_rdata;
   logic [15:0] i_pc = '0;
   logic        o_fetch_internal, o_fetch_external, o_ext_cycle, o_strobe, o_strobe_oe;
   logic        o_pullup_en, o_data_space_select, o_move_stretch, o_weak_pullup_disable, pin;
   logic        f16_int, f16_ext;
   logic [1:0]  o_xram_size;
   logic [31:0] lf = 32'ha14d;
   logic [15:0] pcs [6] = '{16'h0000, 16'h3fff, 16'h4000, 16'h7fff, 16'h8000, 16'hffff};
   int          err_count = 0, compares = 0, supp = 0;
   ebs_top #(.FLASH_32K(1'b1)) dut_u (
      .i_clock(i_clock), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_fetch_req(i_fetch_req), .i_pc(i_pc), .i_data_move(i_data_move),
      .i_table_read(i_table_read), .i_external_access_select(i_external_access_select),
      .o_fetch_internal(o_fetch_internal), .o_fetch_external(o_fetch_external), .o_ext_cycle(o_ext_cycle),
      .o_strobe(o_strobe), .o_strobe_oe(o_strobe_oe), .o_pullup_en(o_pullup_en),
      .o_data_space_select(o_data_space_select), .o_move_stretch(o_move_stretch), .o_xram_size(o_xram_size),
      .o_weak_pullup_disable(o_weak_pullup_disable));
   // smaller flash variant on the same inputs; only its routing is compared
   ebs_top #(.FLASH_32K(1'b0)) dut16_u (
      .i_clock(i_clock), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(), .i_fetch_req(i_fetch_req), .i_pc(i_pc), .i_data_move(i_data_move),
      .i_table_read(i_table_read), .i_external_access_select(i_external_access_select),
      .o_fetch_internal(f16_int), .o_fetch_external(f16_ext), .o_ext_cycle(), .o_strobe(), .o_strobe_oe(),
      .o_pullup_en(), .o_data_space_select(), .o_move_stretch(), .o_xram_size(), .o_weak_pullup_disable());
   ebs_ext_mem mem_u (.i_clock(i_clock), .i_strobe(o_strobe), .i_strobe_oe(o_strobe_oe),
      .i_pullup_en(o_pullup_en), .o_pin(pin));
   // free-running bench clock, 100 ns period
   initial begin
      forever #50 i_clock = ~i_clock;
   end
   // one comparison, counted, reported at once on mismatch
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock) begin i_addr <= a; i_wdata <= d; i_wr <= 1'b1; end
      @(posedge i_clock) i_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clock) begin i_addr <= a; i_rd <= 1'b1; end
      @(posedge i_clock) i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   // model: pin low sends all fetches out, else only above the flash top
   task automatic fetch(input logic [15:0] a);
      int e, e16;
      logic [3:0] x;
      e = (i_external_access_select === 1'b0) || (a > EBS_TOP_32K);
      e16 = (i_external_access_select === 1'b0) || (a > EBS_TOP_16K);
      x = {e[0], !e[0], e[0], e[0] || supp == 0};
      @(posedge i_clock) begin i_pc <= a; i_fetch_req <= 1'b1; end
      @(posedge i_clock) i_fetch_req <= 1'b0;
      #1 chk({o_fetch_external, o_fetch_internal, o_ext_cycle, o_strobe_oe}, 16'(x));
      chk({f16_ext, f16_int}, {e16[0], !e16[0]});
   endtask
   // counts driven strobe-high cycles over two machine cycles
   task automatic count_hi(output int n);
      n = 0;
      repeat (2 * EBS_MACHINE_CYCLE) begin
         @(posedge i_clock) #1;
         n += (o_strobe === 1'b1 && o_strobe_oe === 1'b1);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic complete_run;
      $display("mismatches %0d of %0d comparisons", err_count, compares);
      if (err_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // watchdog well beyond the expected run length
   initial begin
      repeat (5000) @(posedge i_clock);
      err_count++;
      complete_run();
   end
   initial begin
      logic [7:0] d;
      int n;
      repeat (5) @(posedge i_clock);
      i_srst <= 1'b0;
      reg_rd(EBS_AUX_BUS_CTRL_ADDR, d);
      chk(d, EBS_AUX_RESET_VAL);
      count_hi(n);
      chk(16'(n), 16'(2 * EBS_STROBE_HIGH));
      // enable low: a write to the control register must not land
      @(posedge i_clock) i_ce <= 1'b0;
      reg_wr(EBS_AUX_BUS_CTRL_ADDR, 8'h01);
      @(posedge i_clock) i_ce <= 1'b1;
      reg_rd(EBS_AUX_BUS_CTRL_ADDR, d);
      chk(d, EBS_AUX_RESET_VAL);
      foreach (pcs[i]) fetch(pcs[i]);
      reg_wr(EBS_AUX_BUS_CTRL_ADDR, 8'hff);
      supp = 1;
      reg_rd(EBS_AUX_BUS_CTRL_ADDR, d);
      chk(d, 8'hff & EBS_AUX_WRITE_MASK);
      chk({o_weak_pullup_disable, o_move_stretch, o_xram_size, o_data_space_select}, 5'h1f);
      reg_rd(8'h00, d);
      chk(d, 8'h00);
      count_hi(n);
      chk(16'(n), 16'h0000);
      chk({o_strobe_oe, o_pullup_en, pin}, 3'b011);
      // external data moves and table reads still drive the strobe while suppressed
      for (int k = 0; k < 2; k++) begin
         @(posedge i_clock) begin i_data_move <= (k == 0); i_table_read <= (k == 1); end
         @(posedge i_clock) begin i_data_move <= 1'b0; i_table_read <= 1'b0; end
         #1 chk({o_strobe_oe, o_ext_cycle, o_strobe}, 3'b111);
      end
      // status: last access a table read, access pin high, larger flash
      reg_rd(EBS_STATUS_ADDR, d);
      chk(d, {4'h0, EBS_ACC_TABLE_READ, 1'b1, 1'b1});
      for (int k = 0; k < 16; k++) begin
         lf = lfsr(lf);
         fetch(lf[15:0]);
      end
      @(posedge i_clock) i_external_access_select <= 1'b0;
      repeat (4) @(posedge i_clock);
      foreach (pcs[i]) fetch(pcs[i]);
      reg_rd(EBS_STATUS_ADDR, d);
      chk(d, {4'h0, EBS_ACC_FETCH, 1'b0, 1'b1});
      // second reset in mid-run clears the suppress bit again
      @(posedge i_clock) i_srst <= 1'b1;
      @(posedge i_clock) i_srst <= 1'b0;
      supp = 0;
      reg_rd(EBS_AUX_BUS_CTRL_ADDR, d);
      chk(d, EBS_AUX_RESET_VAL);
      count_hi(n);
      chk(16'(n), 16'(2 * EBS_STROBE_HIGH));
      complete_run();
   end
endmodule
`default_nettype wire
